// *** hdl/sscr_status_reg.sv ***
// sscr_status_reg: status and self-check part of the system control register
// assumes: register accesses arrive as one-cycle strobes from the serial frame decoder;
// detector inputs come straight from the analog comparators
//
// Operation
// - supply-low flag reads 1 while the supply is below 2.8 V and 0 above it.
// - crystal-fail flag in bit 27 is set while the crystal is stopped.
// - a stopped crystal switches the serial interface clock to the RC backup clock.
// - bit 23 reads 0 but its written value still takes part in the self-check.
// - any reset clears the supply-low latch in bit 22.
// - the supply-low latch is set whenever the supply-low flag is high.
// - the supply-low latch holds while the supply-low flag is low and the register is not written.
// - a write to the register while the supply-low flag is low clears the supply-low latch whatever the data.
// - the leakage flag in bit 21 follows the reference capacitor leak detector.
// - host reads and writes never alter the leakage flag.
// - the self-check fail flag in bit 20 reads 1 after reset.
// - the self-check fail flag is 0 only when bits 24..16 are the inverse of bits 8..0.
// - only a write of the exact inverse pattern clears the self-check fail flag.
// - the configuration check result is readable in bit 19.
// - the config words plus the checksum word must sum to all ones, else bit 19 reads 1.
`timescale 1ns/1ps
module sscr_status_reg #(
  parameter int unsigned NUM_CFG = sscr_pkg::CFG_WORDS
) (
  input  wire logic                                clk_i,
  input  wire logic                                rst_b_i,
  // register access from the serial frame decoder
  input  wire logic                                reg_wr_i,
  input  wire logic                                reg_rd_i,
  input  wire logic [sscr_pkg::ADDR_W-1:0]         reg_addr_i,
  input  wire logic [sscr_pkg::DATA_W-1:0]         reg_wdata_i,
  output logic [sscr_pkg::DATA_W-1:0]              reg_rdata_o,
  output logic                                     reg_rvalid_o,
  // analog detectors
  input  wire logic                                supply_low_raw_i,
  input  wire logic                                crystal_fail_raw_i,
  input  wire logic                                leak_raw_i,
  // protected configuration words and checksum word
  input  wire logic [NUM_CFG-1:0][sscr_pkg::DATA_W-1:0] cfg_words_i,
  input  wire logic [sscr_pkg::DATA_W-1:0]         cksum_i,
  // status outputs
  output logic                                     uart_rc_clk_sel_o,
  output logic                                     supply_low_latch_o,
  output logic                                     selfcheck_fail_o,
  output logic                                     cfg_verify_fail_o
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] sscr_cfg_sum(
    input logic [NUM_CFG-1:0][31:0] words,
    input logic [31:0]              ck
  );
    logic [31:0] acc;
    acc = ck;
    for (int i = 0; i < NUM_CFG; i++) begin
      acc = acc + words[i];
    end
    return acc;
  endfunction

  function automatic logic sscr_is_inverse(input logic [24:0] sh);
    return (sh[sscr_pkg::CHK_HI_POS +: sscr_pkg::CHK_W] ==
            ~sh[sscr_pkg::CHK_LO_POS +: sscr_pkg::CHK_W]);
  endfunction

  // ------------------------------------------------------------
  // detector synchronisation
  // ------------------------------------------------------------
  sscr_det_if det ();

  sscr_det_sync u_sync (
    .clk_i              (clk_i),
    .rst_b_i            (rst_b_i),
    .supply_low_raw_i   (supply_low_raw_i),
    .crystal_fail_raw_i (crystal_fail_raw_i),
    .leak_raw_i         (leak_raw_i),
    .det                (det)
  );

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic hit;
  wire logic wr_hit;
  wire logic rd_hit;

  assign hit    = (reg_addr_i == sscr_pkg::SYS_CTRL_ADDR);
  assign wr_hit = reg_wr_i && hit;
  assign rd_hit = reg_rd_i && hit;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [sscr_pkg::SHADOW_W-1:0] shadow_q;
  logic [sscr_pkg::SHADOW_W-1:0] shadow_d;
  logic                          latch_q;
  logic                          latch_d;
  logic                          selfchk_q;
  logic                          selfchk_d;
  logic                          cfg_fail_q;
  logic                          cfg_fail_d;
  logic [sscr_pkg::DATA_W-1:0]   rdata_q;
  logic [sscr_pkg::DATA_W-1:0]   rdata_d;
  logic                          rvalid_q;
  logic [sscr_pkg::DATA_W-1:0]   read_word;

  // host copy of the self-check bits, only a write changes it
  assign shadow_d = wr_hit ? reg_wdata_i[sscr_pkg::SHADOW_W-1:0] : shadow_q;

  // set beats the write clear so no supply dip is lost
  assign latch_d = det.supply_low ? 1'b1 :
                   wr_hit         ? 1'b0 :
                                    latch_q;

  // shadow only moves on writes, so only a write can clear this
  assign selfchk_d = ~sscr_is_inverse(shadow_d);

  assign cfg_fail_d = (sscr_cfg_sum(cfg_words_i, cksum_i) != sscr_pkg::CFG_SUM_PASS);

  // ------------------------------------------------------------
  // read word
  // ------------------------------------------------------------
  always_comb begin
    read_word                                = 32'h0000_0000;
    read_word[sscr_pkg::SHADOW_W-1:0]        = shadow_q;
    read_word[sscr_pkg::RSVD_ZERO_BIT]       = 1'b0;
    read_word[sscr_pkg::SUPPLY_LOW_BIT]      = det.supply_low;
    read_word[sscr_pkg::CRYSTAL_FAIL_BIT]    = det.crystal_fail;
    read_word[sscr_pkg::SUPPLY_LATCH_BIT]    = latch_q;
    read_word[sscr_pkg::LEAK_BIT]            = det.leak;
    read_word[sscr_pkg::SELFCHK_FAIL_BIT]    = selfchk_q;
    read_word[sscr_pkg::CFG_VERIFY_BIT]      = cfg_fail_q;
  end

  // unmapped address reads as zero
  assign rdata_d = rd_hit   ? read_word :
                   reg_rd_i ? 32'h0000_0000 :
                              rdata_q;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shadow_q   <= sscr_pkg::SHADOW_RST;
      latch_q    <= 1'b0;
      selfchk_q  <= sscr_pkg::SELFCHK_FAIL_RST;
      cfg_fail_q <= sscr_pkg::CFG_VERIFY_RST;
    end else begin
      shadow_q   <= shadow_d;
      latch_q    <= latch_d;
      selfchk_q  <= selfchk_d;
      cfg_fail_q <= cfg_fail_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= reg_rd_i;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata_o        = rdata_q;
  assign reg_rvalid_o       = rvalid_q;
  assign uart_rc_clk_sel_o  = det.crystal_fail;
  assign supply_low_latch_o = latch_q;
  assign selfcheck_fail_o   = selfchk_q;
  assign cfg_verify_fail_o  = cfg_fail_q;

endmodule

// *** hdl/sscr_pkg.sv ***
// sscr_pkg: constants for the system status and self-check register
// assumes: 32-bit register data, 9-bit word address from the serial frame decoder
package sscr_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W            = 9;
  localparam int unsigned DATA_W            = 32;
  localparam logic [8:0]  SYS_CTRL_ADDR     = 9'h180;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned SUPPLY_LOW_BIT    = 28;
  localparam int unsigned CRYSTAL_FAIL_BIT  = 27;
  localparam int unsigned RSVD_ZERO_BIT     = 23;
  localparam int unsigned SUPPLY_LATCH_BIT  = 22;
  localparam int unsigned LEAK_BIT          = 21;
  localparam int unsigned SELFCHK_FAIL_BIT  = 20;
  localparam int unsigned CFG_VERIFY_BIT    = 19;
  localparam int unsigned CHK_LO_POS        = 0;
  localparam int unsigned CHK_HI_POS        = 16;
  localparam int unsigned CHK_W             = 9;
  localparam int unsigned SHADOW_W          = 25;

  // ------------------------------------------------------------
  // reset values and constants
  // ------------------------------------------------------------
  localparam logic [24:0] SHADOW_RST        = 25'h000_0000;
  localparam logic        SELFCHK_FAIL_RST  = 1'b1;
  localparam logic        CFG_VERIFY_RST    = 1'b1;
  localparam logic [31:0] CFG_SUM_PASS      = 32'hFFFF_FFFF;
  localparam int unsigned CFG_WORDS         = 24;
  localparam int unsigned SYNC_STAGES       = 2;

endpackage

// *** hdl/sscr_det_if.sv ***
// sscr_det_if: detector levels between the synchroniser and the register
// assumes: one clock domain, levels already free of glitches at the analog side
`timescale 1ns/1ps
interface sscr_det_if;
  logic supply_low;
  logic crystal_fail;
  logic leak;

  modport sync_side (output supply_low, output crystal_fail, output leak);
  modport reg_side  (input  supply_low, input  crystal_fail, input  leak);
endinterface

// *** hdl/sscr_det_sync.sv ***
// sscr_det_sync: two-stage synchroniser for the analog detector levels
// assumes: detector levels may change at any time relative to clk_i
`timescale 1ns/1ps
module sscr_det_sync (
  input  wire logic      clk_i,
  input  wire logic      rst_b_i,
  input  wire logic      supply_low_raw_i,
  input  wire logic      crystal_fail_raw_i,
  input  wire logic      leak_raw_i,
  sscr_det_if.sync_side  det
);

  logic [2:0] meta_q;
  logic [2:0] sync_q;

  // ------------------------------------------------------------
  // first stage read only by the second
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end else begin
      meta_q <= {leak_raw_i, crystal_fail_raw_i, supply_low_raw_i};
      sync_q <= meta_q;
    end
  end

  assign det.supply_low   = sync_q[0];
  assign det.crystal_fail = sync_q[1];
  assign det.leak         = sync_q[2];

endmodule

// *** bench/sscr_status_props.sv ***
// sscr_status_props: port assertions for the status register
// assumes: bound to sscr_status_reg, one clock domain
`timescale 1ns/1ps
module sscr_status_props #(
  parameter int unsigned NUM_CFG = sscr_pkg::CFG_WORDS
) (
  input wire logic                                      clk_i,
  input wire logic                                      rst_b_i,
  input wire logic                                      reg_wr_i,
  input wire logic                                      reg_rd_i,
  input wire logic [sscr_pkg::ADDR_W-1:0]               reg_addr_i,
  input wire logic [sscr_pkg::DATA_W-1:0]               reg_wdata_i,
  input wire logic [sscr_pkg::DATA_W-1:0]               reg_rdata_o,
  input wire logic                                      reg_rvalid_o,
  input wire logic                                      supply_low_raw_i,
  input wire logic                                      crystal_fail_raw_i,
  input wire logic                                      leak_raw_i,
  input wire logic [NUM_CFG-1:0][sscr_pkg::DATA_W-1:0]  cfg_words_i,
  input wire logic [sscr_pkg::DATA_W-1:0]               cksum_i,
  input wire logic                                      uart_rc_clk_sel_o,
  input wire logic                                      supply_low_latch_o,
  input wire logic                                      selfcheck_fail_o,
  input wire logic                                      cfg_verify_fail_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire       hit = reg_wr_i && reg_addr_i == sscr_pkg::SYS_CTRL_ADDR;
  wire [8:0] lo  = reg_wdata_i[8:0];
  wire [8:0] hi  = reg_wdata_i[24:16];
  rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
  rvalid_once_a: assert property (!reg_rd_i |=> !reg_rvalid_o) else $error("stray read valid");
  rsvd_zero_a: assert property (reg_rvalid_o |-> !reg_rdata_o[23])
    else $error("bit 23 read as one");
  latch_set_a: assert property (supply_low_raw_i |-> ##3 supply_low_latch_o)
    else $error("latch not set");
  latch_clr_a: assert property (
    hit && !$past(supply_low_raw_i, 2) |=> !supply_low_latch_o)
    else $error("latch not cleared by write");
  latch_hold_a: assert property (
    !hit && !$past(supply_low_raw_i, 2) |=> $stable(supply_low_latch_o))
    else $error("latch moved");
  chk_pass_a: assert property (hit && hi == ~lo |=> !selfcheck_fail_o)
    else $error("self check not cleared");
  chk_fail_a: assert property (hit && hi != ~lo |=> selfcheck_fail_o)
    else $error("self check cleared wrongly");
  rc_clock_a: assert property (crystal_fail_raw_i [*2] |=> uart_rc_clk_sel_o)
    else $error("rc clock not selected");
  cover property (hit && hi == ~lo);
  cover property (supply_low_latch_o && !supply_low_raw_i);
  cover property (reg_rvalid_o && reg_rdata_o[21]);
endmodule
bind sscr_status_reg sscr_status_props #(.NUM_CFG(NUM_CFG)) u_props (.*);

// *** bench/sscr_host_model.sv ***
// sscr_host_model: host side issuing register strobes
// assumes: strobes change at the falling edge
`timescale 1ns/1ps
module sscr_host_model (
  input  wire logic        clk_i,
  input  wire logic        rvalid_i,
  input  wire logic [31:0] rdata_i,
  output logic             wr_o = 1'b0,
  output logic             rd_o = 1'b0,
  output logic [8:0]       addr_o = 9'h000,
  output logic [31:0]      wdata_o = 32'h0000_0000
);
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(negedge clk_i);
    {wr_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge clk_i);
    {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [8:0] a, output logic [31:0] d, output bit ok);
    @(negedge clk_i);
    {rd_o, addr_o} = {1'b1, a};
    @(negedge clk_i);
    {rd_o, addr_o} = {1'b0, ~a};
    ok = rvalid_i;
    for (int i = 0; i < 3 && !ok; i++) begin
      @(negedge clk_i);
      ok = rvalid_i;
    end
    d = rdata_i;
  endtask
  // inverse of the low bits into the upper bits
  task automatic selfchk(input logic [8:0] lo);
    wr(sscr_pkg::SYS_CTRL_ADDR, {7'h00, ~lo, 7'h00, lo});
  endtask
endmodule

// *** bench/tb_top.sv ***
// tb_top: self-checking bench for sscr_status_reg
// assumes: host model drives the strobes, bench drives detectors
`timescale 1ns/1ps
module tb_top;
  localparam logic [8:0] A = sscr_pkg::SYS_CTRL_ADDR;
  logic clk_i = 0, rst_b_i = 0, sl = 0, cf = 0, lk = 0, wr, rd, rv, sel, lat, scf, cvf;
  logic [23:0][31:0] cfg = '0;
  logic [31:0]       ck = '0, d, w, s, wd, rdat;
  logic [8:0]        ad;
  int                num_errors = 0, checks_done = 0;
  bit                ok;
  initial forever #12.5 clk_i = ~clk_i;
  sscr_status_reg dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(ad), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
    .supply_low_raw_i(sl), .crystal_fail_raw_i(cf), .leak_raw_i(lk), .cfg_words_i(cfg),
    .cksum_i(ck), .uart_rc_clk_sel_o(sel), .supply_low_latch_o(lat),
    .selfcheck_fail_o(scf), .cfg_verify_fail_o(cvf));
  sscr_host_model host (.clk_i(clk_i), .rvalid_i(rv), .rdata_i(rdat), .wr_o(wr), .rd_o(rd),
    .addr_o(ad), .wdata_o(wd));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [31:0] e);
    host.rd(a, d, ok);
    if (!ok) begin
      num_errors++;
      complete_run();
    end else begin
      chk(d, e);
    end
  endtask
  // st = supply, crystal, latch, leak, cfg fail
  function automatic logic [31:0] ew(input logic [31:0] v, input logic [4:0] st);
    ew = (v & 32'h0107_FFFF) |
      {3'h0, st[4:3], 4'h0, st[2:1], v[24:16] != ~v[8:0], st[0], 19'h0_0000};
  endfunction
  initial begin
    void'($urandom(32'hc3f5));
    repeat (12) @(posedge clk_i);
    @(negedge clk_i) rst_b_i = 1;
    rd_chk(A, 32'h0018_0000);
    for (int i = 0; i < 8; i++) begin
      w = $urandom;
      if (i % 2) host.selfchk(w[8:0]);
      else host.wr(A, w);
      if (i % 2) w = {7'h00, ~w[8:0], 7'h00, w[8:0]};
      rd_chk(A, ew(w, 5'h01));
    end
    chk(32'(scf), 32'h0);
    w = 32'h01D5_00AA;
    host.wr(A, w);
    chk(32'(scf), 32'h1);
    host.wr(9'h181, 32'h0155_00AA);
    rd_chk(A, ew(w, 5'h01));
    rd_chk(9'h181, 32'h0000_0000);
    $display("test self check done");
    sl = 1;
    repeat (4) @(negedge clk_i);
    rd_chk(A, ew(w, 5'h15));
    chk(32'(lat), 32'h1);
    sl = 0;
    repeat (4) @(negedge clk_i);
    rd_chk(A, ew(w, 5'h05));
    chk(32'(lat), 32'h1);
    host.wr(A, w);
    rd_chk(A, ew(w, 5'h01));
    $display("test supply done");
    {lk, cf} = 2'b11;
    repeat (4) @(negedge clk_i);
    host.wr(A, w);
    chk(32'(sel), 32'h1);
    rd_chk(A, ew(w, 5'h0B));
    {lk, cf} = 2'b00;
    s = 0;
    for (int i = 0; i < 24; i++) begin
      cfg[i] = $urandom;
      s += cfg[i];
    end
    ck = 32'hFFFF_FFFF - s;
    repeat (4) @(negedge clk_i);
    chk(32'(cvf), 32'h0);
    rd_chk(A, ew(w, 5'h00));
    ck = ck + 1;
    repeat (3) @(negedge clk_i);
    chk(32'(cvf), 32'h1);
    $display("test detectors done");
    complete_run();
  end
endmodule
